// [pkg/uar_map.svh]
/*
  Register offsets, field positions, reset values and timing counts of the
  asynchronous receive back end. Assumes an 8-bit register port.
*/
`ifndef UAR_MAP_SVH
`define UAR_MAP_SVH
// Register offsets
`define UAR_OFS_STATUS_CTRL 2'h0
`define UAR_OFS_DATA 2'h1
`define UAR_OFS_IRQ 2'h2
// Fields of receive_status_control
`define UAR_BIT_PORT_EN 7
`define UAR_BIT_NINE_SEL 6
`define UAR_BIT_CONT_EN 4
`define UAR_BIT_ADDR_DET 3
`define UAR_BIT_FRAME_ERR 2
`define UAR_BIT_OVERRUN 1
`define UAR_BIT_NINTH 0
// Fields of the interrupt register
`define UAR_BIT_IRQ_EN 0
`define UAR_BIT_IRQ_FLAG 1
// Reset value of every control bit
`define UAR_RST_BIT 1'b0
// Oversampling ticks within one bit time
`define UAR_START_CHECK 4'h7
`define UAR_VOTE_FIRST 4'h6
`define UAR_VOTE_LAST 4'h8
`define UAR_LAST_TICK 4'hF
// Data bits per character and storage
`define UAR_BITS_EIGHT 4'h8
`define UAR_BITS_NINE 4'h9
`define UAR_FIFO_DEPTH 2
`define UAR_ENTRY_W 10
`endif

// [pkg/uar_pkg.sv]
/*
  Types shared by the receive back end: receiver states and the state record
  of the top module. Assumes uar_map.svh is on the include path.
*/
package uar_pkg;
  // Receiver sequence states
  typedef enum logic [1:0] {
    UAR_IDLE = 2'b00,
    UAR_START = 2'b01,
    UAR_DATA = 2'b10,
    UAR_STOP = 2'b11
  } uar_rx_state_e;

  // Complete state of the receiver top module
  typedef struct packed {
    uar_rx_state_e st;
    logic [3:0] tick_cnt;
    logic [3:0] bit_cnt;
    logic [2:0] vote;
    logic [8:0] receive_shift_register;
    logic line_prev;
    logic serial_port_enable;
    logic nine_bit_receive_select;
    logic continuous_receive_enable;
    logic address_detect_enable;
    logic receive_interrupt_enable;
    logic overrun_error_flag;
    logic [7:0] rdata;
  } uar_rx_regs_s;
endpackage

// [design/uar_sync2.sv]
/*
  Two-stage synchroniser for the serial input pin.
  Assumes the pin idles high, so both stages reset to one.
*/
`timescale 1ns/10ps
`default_nettype none
module uar_sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous level in, synchronised level out
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic meta;
    logic stable;
  } uar_sync_s;
  uar_sync_s s_q;
  uar_sync_s s_d;

  // First stage feeds only the second
  always_comb
  begin
    s_d.meta = async_in;
    s_d.stable = s_q.meta;
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= 2'h3;
    else
      s_q <= s_d;
  end

  assign sync_out = s_q.stable;
endmodule // uar_sync2
`default_nettype wire

// [design/uar_rx_fifo.sv]
/*
  Small receive FIFO whose oldest entry comes out of a register.
  Assumes the writer never pushes when full; such a push is dropped.
*/
`timescale 1ns/10ps
`default_nettype none
`include "uar_map.svh"
module uar_rx_fifo #(
  parameter int DEPTH = `UAR_FIFO_DEPTH,
  parameter int W = `UAR_ENTRY_W
) (
  // Clock, reset and flush
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // Write side
  input wire logic push,
  input wire logic [W-1:0] push_data,
  // Read side
  input wire logic pop,
  output logic [W-1:0] head,
  output logic empty,
  output logic full,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] cnt;
    logic [W-1:0] head;
  } uar_fifo_s;
  uar_fifo_s s_q;
  uar_fifo_s s_d;
  logic do_push;
  logic do_pop;

  // Pointer step with wrap
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Next state; head holds the oldest entry, or zero when empty
  always_comb
  begin
    s_d = s_q;
    do_push = push && (s_q.cnt != CW'(DEPTH));
    do_pop = pop && (s_q.cnt != '0);
    if (flush)
    begin
      s_d.wptr = '0;
      s_d.rptr = '0;
      s_d.cnt = '0;
    end
    else
    begin
      if (do_push)
      begin
        s_d.mem[s_q.wptr] = push_data;
        s_d.wptr = step(s_q.wptr);
      end
      if (do_pop)
        s_d.rptr = step(s_q.rptr);
      case ({do_push, do_pop})
        2'b10: s_d.cnt = s_q.cnt + 1'b1;
        2'b01: s_d.cnt = s_q.cnt - 1'b1;
        default: s_d.cnt = s_q.cnt;
      endcase
    end
    s_d.head = (s_d.cnt == '0) ? '0 : s_d.mem[s_d.rptr];
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign head = s_q.head;
  assign count = s_q.cnt;
  assign empty = (s_q.cnt == '0);
  assign full = (s_q.cnt == CW'(DEPTH));
endmodule // uar_rx_fifo
`default_nettype wire

// [design/uar_receiver.sv]
/*
  Asynchronous serial receive back end: start check, majority sampling,
  eight or nine data bits, stop check, two-entry FIFO with framing error per
  character, overrun handling, address detection and an 8-bit register port.
  Assumes a 16x bit-rate tick from a separate baud generator on clk.

*/
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "uar_map.svh"
module uar_receiver (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Serial line and oversampling tick
  input wire logic rx_pin,
  input wire logic rx_tick16,
  // Interrupt status
  output logic receive_interrupt_flag,
  output logic rx_irq
);
  uar_pkg::uar_rx_regs_s s_q;
  uar_pkg::uar_rx_regs_s s_d;
  logic line_s;
  logic rx_active;
  logic addr_on;
  logic frame_done;
  logic stop_bad;
  logic maj;
  logic accept;
  logic rx_push;
  logic fifo_pop;
  logic fifo_flush;
  logic fifo_empty;
  logic fifo_full;
  logic [1:0] fifo_count;
  logic [2:0] vote_n;
  logic [3:0] nbits;
  logic [8:0] char9;
  logic [9:0] push_word;
  logic [9:0] fifo_head;
  logic framing_error_flag;
  logic received_ninth_bit;

  // Pin synchroniser
  uar_sync2 u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(rx_pin),
    .sync_out(line_s)
  );

  // Character store, framing bit beside the data
  uar_rx_fifo #(
    .DEPTH(`UAR_FIFO_DEPTH),
    .W(`UAR_ENTRY_W)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(fifo_flush),
    .push(rx_push),
    .push_data(push_word),
    .pop(fifo_pop),
    .head(fifo_head),
    .empty(fifo_empty),
    .full(fifo_full),
    .count(fifo_count)
  );

  // Receiver enable and mode decode
  assign rx_active = s_q.serial_port_enable && s_q.continuous_receive_enable;
  assign addr_on = s_q.address_detect_enable && s_q.nine_bit_receive_select;
  assign nbits = s_q.nine_bit_receive_select ? `UAR_BITS_NINE : `UAR_BITS_EIGHT;
  assign fifo_flush = !s_q.serial_port_enable;

  // Vote window and majority of three samples
  assign vote_n = {s_q.vote[1:0], line_s};
  assign maj = (vote_n[0] & vote_n[1]) | (vote_n[0] & vote_n[2]) |
               (vote_n[1] & vote_n[2]);

  // Character alignment: eight-bit data sits one place high in the shifter
  assign char9 = s_q.nine_bit_receive_select ? s_q.receive_shift_register :
                 {1'b0, s_q.receive_shift_register[8:1]};

  // End of frame on the stop-bit vote
  assign frame_done = (s_q.st == uar_pkg::UAR_STOP) && rx_tick16 &&
                      (s_q.tick_cnt == `UAR_VOTE_LAST);
  assign stop_bad = !maj;

  // Acceptance: framing errors pass, overrun and address filter block
  assign accept = frame_done && rx_active && !s_q.overrun_error_flag &&
                  (!addr_on || char9[8]);
  assign rx_push = accept && !fifo_full;
  assign push_word = {stop_bad, char9};

  // Data register read pops the FIFO
  assign fifo_pop = reg_rd && (reg_addr == `UAR_OFS_DATA);

  // Status of the oldest unread character
  assign framing_error_flag = fifo_head[9];
  assign received_ninth_bit = fifo_head[8];

  // Receive flag and gated request; framing plays no part
  assign receive_interrupt_flag = rx_active && !fifo_empty;
  assign rx_irq = receive_interrupt_flag && s_q.receive_interrupt_enable;
  assign reg_rdata = s_q.rdata;

  // Receiver sequence, control writes and read data
  always_comb
  begin
    s_d = s_q;
    s_d.line_prev = line_s;
    case (s_q.st)
      uar_pkg::UAR_IDLE:
      begin
        if (rx_active && s_q.line_prev && !line_s)
        begin
          s_d.st = uar_pkg::UAR_START;
          s_d.tick_cnt = 4'h0;
        end
      end
      uar_pkg::UAR_START:
      begin
        if (rx_tick16)
        begin
          s_d.tick_cnt = s_q.tick_cnt + 4'h1;
          if ((s_q.tick_cnt == `UAR_START_CHECK) && line_s)
            s_d.st = uar_pkg::UAR_IDLE;
          else if (s_q.tick_cnt == `UAR_LAST_TICK)
          begin
            s_d.st = uar_pkg::UAR_DATA;
            s_d.bit_cnt = 4'h0;
          end
        end
      end
      uar_pkg::UAR_DATA:
      begin
        if (rx_tick16)
        begin
          s_d.tick_cnt = s_q.tick_cnt + 4'h1;
          if ((s_q.tick_cnt >= `UAR_VOTE_FIRST) && (s_q.tick_cnt <= `UAR_VOTE_LAST))
            s_d.vote = vote_n;
          if (s_q.tick_cnt == `UAR_VOTE_LAST)
          begin
            s_d.receive_shift_register = {maj, s_q.receive_shift_register[8:1]};
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
            if ((s_q.bit_cnt + 4'h1) == nbits)
              s_d.st = uar_pkg::UAR_STOP;
          end
        end
      end
      uar_pkg::UAR_STOP:
      begin
        if (rx_tick16)
        begin
          s_d.tick_cnt = s_q.tick_cnt + 4'h1;
          if ((s_q.tick_cnt >= `UAR_VOTE_FIRST) && (s_q.tick_cnt <= `UAR_VOTE_LAST))
            s_d.vote = vote_n;
          if (s_q.tick_cnt == `UAR_VOTE_LAST)
            s_d.st = uar_pkg::UAR_IDLE;
        end
      end
      default:
      begin
        s_d.st = uar_pkg::UAR_IDLE;
      end
    endcase

    // Overrun: set on a full FIFO, held until receive or port disable
    if (accept && fifo_full)
      s_d.overrun_error_flag = 1'b1;
    if (!rx_active)
    begin
      s_d.st = uar_pkg::UAR_IDLE;
      s_d.overrun_error_flag = 1'b0;
    end

    // Control writes; status bits are not writable
    if (reg_wr && (reg_addr == `UAR_OFS_STATUS_CTRL))
    begin
      s_d.serial_port_enable = reg_wdata[`UAR_BIT_PORT_EN];
      s_d.nine_bit_receive_select = reg_wdata[`UAR_BIT_NINE_SEL];
      s_d.continuous_receive_enable = reg_wdata[`UAR_BIT_CONT_EN];
      s_d.address_detect_enable = reg_wdata[`UAR_BIT_ADDR_DET];
    end
    if (reg_wr && (reg_addr == `UAR_OFS_IRQ))
      s_d.receive_interrupt_enable = reg_wdata[`UAR_BIT_IRQ_EN];

    // Read data for the cycle after the strobe only
    s_d.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        `UAR_OFS_STATUS_CTRL:
        begin
          s_d.rdata[`UAR_BIT_PORT_EN] = s_q.serial_port_enable;
          s_d.rdata[`UAR_BIT_NINE_SEL] = s_q.nine_bit_receive_select;
          s_d.rdata[`UAR_BIT_CONT_EN] = s_q.continuous_receive_enable;
          s_d.rdata[`UAR_BIT_ADDR_DET] = s_q.address_detect_enable;
          s_d.rdata[`UAR_BIT_FRAME_ERR] = framing_error_flag;
          s_d.rdata[`UAR_BIT_OVERRUN] = s_q.overrun_error_flag;
          s_d.rdata[`UAR_BIT_NINTH] = received_ninth_bit;
        end
        `UAR_OFS_DATA:
        begin
          s_d.rdata = fifo_head[7:0];
        end
        `UAR_OFS_IRQ:
        begin
          s_d.rdata[`UAR_BIT_IRQ_EN] = s_q.receive_interrupt_enable;
          s_d.rdata[`UAR_BIT_IRQ_FLAG] = receive_interrupt_flag;
        end
        default:
        begin
          s_d.rdata = 8'h00;
        end
      endcase
    end
  end

  // Reset state; edge detector starts at the idle line level
  localparam uar_pkg::uar_rx_regs_s RX_RST =
    '{st: uar_pkg::UAR_IDLE, line_prev: 1'b1, default: '0};

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= RX_RST;
    else
      s_q <= s_d;
  end

  // Checks on the guarded behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_FRAME_STORED: assert property (rx_push && fifo_empty
                                     |=> framing_error_flag == $past(stop_bad))
    else $error("framing bit not stored with character");

  AST_NINTH_STORED: assert property (rx_push && fifo_empty
                                     |=> received_ninth_bit == $past(char9[8]))
    else $error("ninth bit not stored with character");

  AST_POP_ADVANCE: assert property (fifo_pop && !fifo_empty && !rx_push && !fifo_flush
                                    |=> fifo_count == $past(fifo_count) - 2'd1)
    else $error("data read did not advance the FIFO");

  AST_PORT_RESET: assert property (!s_q.serial_port_enable |=> !framing_error_flag &&
                                   !s_q.overrun_error_flag)
    else $error("port disable did not reset the receiver");

  AST_CONT_KEEPS_FRAME: assert property (s_q.serial_port_enable &&
                                         !s_q.continuous_receive_enable && !fifo_pop
                                         |=> $stable(framing_error_flag))
    else $error("framing flag moved while receive disabled");

  AST_IRQ_NEEDS_DATA: assert property (rx_irq |-> !fifo_empty && rx_active)
    else $error("request raised without unread data");

  AST_OVERRUN_SET: assert property (accept && fifo_full |=> s_q.overrun_error_flag)
    else $error("overrun not flagged on full FIFO");

  AST_OVERRUN_BLOCKS: assert property (s_q.overrun_error_flag |-> !rx_push)
    else $error("character queued during overrun");

  AST_OVERRUN_HOLDS: assert property (s_q.overrun_error_flag && rx_active
                                      |=> s_q.overrun_error_flag)
    else $error("overrun cleared while receiver enabled");

  AST_NINE_BITS: assert property ($rose(s_q.st == uar_pkg::UAR_STOP) |->
                                  $past(s_q.bit_cnt) + 4'h1 == nbits)
    else $error("wrong number of data bits shifted");

  AST_ADDR_NINTH: assert property (rx_push && addr_on |=> received_ninth_bit ||
                                   !fifo_empty && $past(!fifo_empty))
    else $error("address mode queued a character without ninth bit");

  AST_FLAG_ON_PUSH: assert property (rx_push && rx_active ##1 rx_active
                                     |-> receive_interrupt_flag)
    else $error("receive flag not set after transfer");

  AST_FALSE_START: assert property (s_q.st == uar_pkg::UAR_START && rx_tick16 &&
                                    s_q.tick_cnt == `UAR_START_CHECK && line_s
                                    |=> s_q.st == uar_pkg::UAR_IDLE)
    else $error("false start not abandoned");

  // Status and store move only on their own events
  AST_STATUS_READ_ONLY: assert property (reg_wr && reg_addr == `UAR_OFS_STATUS_CTRL &&
                                         s_q.serial_port_enable && !rx_push && !fifo_pop
                                         |=> $stable(framing_error_flag) &&
                                         $stable(received_ninth_bit))
    else $error("status bits changed by a register write");

  AST_POP_ONLY_ON_READ: assert property (!fifo_pop && !rx_push && !fifo_flush
                                         |=> $stable(fifo_count))
    else $error("store moved without a data read");

  AST_ADDR_DROP: assert property (frame_done && rx_active && addr_on && !char9[8]
                                  |-> !rx_push ##1 $stable(s_q.overrun_error_flag))
    else $error("address mode kept or overran on a data character");

  // Main scenarios
  COV_FRAMING_QUEUED: cover property (rx_push && push_word[9]);
  COV_OVERRUN: cover property (accept && fifo_full);
  COV_ADDR_DISCARD: cover property (frame_done && rx_active && addr_on && !char9[8]);
  COV_NINE_BIT: cover property (rx_push && s_q.nine_bit_receive_select && char9[8]);
  COV_FALSE_START: cover property (s_q.st == uar_pkg::UAR_START && rx_tick16 &&
                                   s_q.tick_cnt == `UAR_START_CHECK && line_s);
endmodule // uar_receiver
`default_nettype wire

// [sim/uar_tx_model.sv]
/*
  Remote asynchronous transmitter model driving the shared serial line.
  Assumes one clk domain and a 16x bit-rate tick from the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module uar_tx_model (
  // Clock and 16x bit-rate tick
  input wire logic clk,
  input wire logic tick,
  // Serial line toward the receiver
  output logic line
);
  // Line idles high between frames
  initial line = 1'b1;

  // Start, data LSB first, stop (forced low for a bad stop), one idle bit
  task automatic send(input logic [8:0] d, input logic nine, input logic bad_stop);
    logic [11:0] fr;
    int n;
    int b;
    fr = nine ? {1'b1, ~bad_stop, d, 1'b0} : {1'b1, 1'b1, ~bad_stop, d[7:0], 1'b0};
    n = nine ? 12 : 11;
    for (b = 0; b < n; b++)
    begin
      line <= fr[b];
      repeat (16) @(posedge clk iff tick); // Sixteen ticks per bit
    end
  endtask

  // Short low pulse that must not start a character
  task automatic glitch();
    line <= 1'b0;
    repeat (3) @(posedge clk iff tick);
    line <= 1'b1;
    repeat (32) @(posedge clk iff tick);
  endtask
endmodule // uar_tx_model
`default_nettype wire

// [sim/testbench.sv]
/*
  Self-checking bench for the receive back end: register reads are queued
  as expectations and compared one cycle later. Assumes uar_map.svh on the
  include path and the transmitter model beside it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "uar_map.svh"
module testbench;
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic rx_pin;
  logic rx_tick16 = 1'b0;
  logic receive_interrupt_flag;
  logic rx_irq;
  logic [1:0] tick_cnt = 2'h0;
  logic rd_pend = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] c[0:4];
  int mismatches = 0;
  int tests_run = 0;
  int seed = 6931;
  int i;
  localparam logic [1:0] S = `UAR_OFS_STATUS_CTRL;
  localparam logic [1:0] D = `UAR_OFS_DATA;
  localparam logic [1:0] Q = `UAR_OFS_IRQ;

  // 100 ns clock
  always #50 clk = ~clk;

  // Oversampling tick every fourth clock
  always @(posedge clk)
  begin
    tick_cnt <= tick_cnt + 2'h1;
    rx_tick16 <= (tick_cnt == 2'h3);
  end

  uar_receiver uut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin),
    .rx_tick16(rx_tick16), .receive_interrupt_flag(receive_interrupt_flag),
    .rx_irq(rx_irq)
  );

  uar_tx_model tx (.clk(clk), .tick(rx_tick16), .line(rx_pin));

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle register read, expectation queued
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // Read data checked mid-cycle after the strobe
  always @(posedge clk) rd_pend <= reg_rd;
  always @(negedge clk)
  begin
    if (rd_pend && exp_q.size() > 0)
      chk(reg_rdata, exp_q.pop_front());
  end

  // Hang guard
  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 5; i++)
      c[i] = 8'($random(seed));
    // Reset values and unmapped place
    rd(S, 8'h00);
    rd(Q, 8'h00);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    wr(Q, 8'h01);
    wr(S, 8'h97);
    rd(S, 8'h90);
    // A short low pulse is abandoned at the start check
    tx.glitch();
    rd(Q, 8'h01);
    // Good then bad character, each with its own flag
    tx.send({1'b0, c[0]}, 1'b0, 1'b0);
    rd(Q, 8'h03);
    @(negedge clk);
    chk({7'h00, rx_irq}, 8'h01);
    chk({7'h00, receive_interrupt_flag}, 8'h01);
    wr(Q, 8'h00);
    @(negedge clk);
    chk({6'h00, receive_interrupt_flag, rx_irq}, 8'h02);
    wr(Q, 8'h01);
    tx.send({1'b0, c[1]}, 1'b0, 1'b1);
    rd(S, 8'h90);
    rd(D, c[0]);
    rd(S, 8'h94);
    rd(D, c[1]);
    rd(Q, 8'h01);
    @(negedge clk);
    chk({7'h00, receive_interrupt_flag}, 8'h00);
    // Third character overruns the full FIFO, the next one is blocked
    tx.send({1'b0, c[2]}, 1'b0, 1'b1);
    tx.send({1'b0, c[3]}, 1'b0, 1'b1);
    tx.send({1'b0, c[4]}, 1'b0, 1'b0);
    rd(S, 8'h96);
    rd(D, c[2]);
    tx.send({1'b0, c[0]}, 1'b0, 1'b0);
    rd(S, 8'h96);
    wr(S, 8'h80);
    rd(S, 8'h84);
    rd(Q, 8'h01);
    wr(S, 8'h90);
    rd(D, c[3]);
    rd(S, 8'h90);
    // Port disable flushes and clears the framing flag
    tx.send({1'b0, c[4]}, 1'b0, 1'b1);
    rd(S, 8'h94);
    wr(S, 8'h00);
    rd(S, 8'h00);
    wr(S, 8'h90);
    rd(D, 8'h00);
    // Nine-bit characters
    wr(S, 8'hD0);
    tx.send({1'b1, c[0]}, 1'b1, 1'b0);
    tx.send({1'b0, c[1]}, 1'b1, 1'b0);
    rd(S, 8'hD1);
    rd(D, c[0]);
    rd(S, 8'hD0);
    rd(D, c[1]);
    // Address detection set up in order, receive enable last
    wr(S, 8'h80);
    wr(S, 8'hC0);
    wr(S, 8'hC8);
    wr(S, 8'hD8);
    tx.send({1'b0, c[2]}, 1'b1, 1'b0);
    tx.send({1'b1, c[3]}, 1'b1, 1'b0);
    rd(S, 8'hD9);
    rd(D, c[3]);
    rd(Q, 8'h01);
    wr(S, 8'hD0);
    tx.send({1'b0, c[4]}, 1'b1, 1'b0);
    rd(S, 8'hD0);
    rd(D, c[4]);
    wr(S, 8'hD8);
    tx.send({1'b0, c[0]}, 1'b1, 1'b0);
    rd(Q, 8'h01);
    rd(D, 8'h00);
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
